// ### hdl/memory_attribute_access_policy.sv
// Storage attribute access policy: cache use, bus issue and speculation gating
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module memory_attribute_access_policy #(
  parameter int CNT_W = 32
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [attr_policy_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [31:0] req_addr,
  input wire logic [attr_policy_pkg::ATTR_W-1:0] req_attr,
  input wire logic req_xlate_en,
  input wire logic req_hit,
  input wire logic req_required,
  input wire logic req_err,
  input wire logic req_mchk,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_defer,
  output logic resp_cache,
  output logic resp_allocate,
  output logic resp_inhibit,
  output logic resp_error,
  output logic resp_ref_set,
  output logic [3:0] resp_fetch_words,
  output logic bus_req,
  output logic [31:0] bus_addr,
  output logic bus_write,
  output logic bus_instr,
  output logic bus_global,
  output logic bus_burst,
  input wire logic bus_ack,
  input wire logic bus_artry
);
  attr_policy_pkg::bus_state_t state_q, state_d;
  logic [1:0] ctrl_q;
  logic retry_seen_q;
  logic [CNT_W-1:0] issue_cnt_q;
  logic [CNT_W-1:0] defer_cnt_q;
  logic accept, done;
  logic d_inhibit, d_guarded, d_global, d_defer, d_cache, d_go_bus, d_alloc;
  logic d_write, d_instr, d_ref, d_error;
  logic [3:0] d_fetch_words;
  logic h_defer, h_cache, h_alloc, h_inhibit, h_error, h_ref;
  logic [3:0] h_fetch_words;
  logic apb_setup, apb_commit;
  logic [31:0] rd_data;
  logic rd_ok;

  assign accept = req_valid & req_ready;
  assign done = (state_q == attr_policy_pkg::ST_ISSUE) & bus_ack & ~bus_artry;

  // Decode runs on the live request so decisions belong to that access
  attr_decode u_decode (
    .kind(req_kind),
    .addr(req_addr),
    .attr(req_attr),
    .xlate_en(req_xlate_en),
    .hit(req_hit),
    .required(req_required),
    .err(req_err),
    .mchk(req_mchk),
    .cache_en(ctrl_q[attr_policy_pkg::CTRL_CACHE_EN_BIT]),
    .spec_en(ctrl_q[attr_policy_pkg::CTRL_SPEC_EN_BIT]),
    .eff_inhibit(d_inhibit),
    .eff_guarded(d_guarded),
    .global_acc(d_global),
    .defer(d_defer),
    .use_cache(d_cache),
    .go_bus(d_go_bus),
    .allocate(d_alloc),
    .write(d_write),
    .instr(d_instr),
    .ref_set(d_ref),
    .error(d_error),
    .fetch_words(d_fetch_words)
  );

  // Bus sequencing: retry beats acknowledge so the access is reissued whole
  always_comb begin
    state_d = state_q;
    case (state_q)
      attr_policy_pkg::ST_IDLE: begin
        if (accept && d_go_bus) begin
          state_d = attr_policy_pkg::ST_ISSUE;
        end
      end
      attr_policy_pkg::ST_ISSUE: begin
        if (bus_artry) begin
          state_d = attr_policy_pkg::ST_RETRY;
        end else if (bus_ack) begin
          state_d = attr_policy_pkg::ST_IDLE;
        end
      end
      attr_policy_pkg::ST_RETRY: begin
        state_d = attr_policy_pkg::ST_ISSUE;
      end
      default: begin
        state_d = attr_policy_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= attr_policy_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // One outstanding bus access at a time keeps inhibited traffic in order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b1;
      bus_req <= 1'b0;
    end else begin
      req_ready <= (state_d == attr_policy_pkg::ST_IDLE);
      bus_req <= (state_d == attr_policy_pkg::ST_ISSUE);
    end
  end

  // Address-phase attributes latched once per access, never combined
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_addr <= 32'h0000_0000;
      bus_write <= 1'b0;
      bus_instr <= 1'b0;
      bus_global <= 1'b0;
      bus_burst <= 1'b0;
    end else if (accept && d_go_bus) begin
      bus_addr <= req_addr;
      bus_write <= d_write;
      bus_instr <= d_instr;
      bus_global <= d_global;
      bus_burst <= d_alloc;
    end
  end

  // Decision held while the bus access is outstanding
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      h_defer <= 1'b0;
      h_cache <= 1'b0;
      h_alloc <= 1'b0;
      h_inhibit <= 1'b0;
      h_error <= 1'b0;
      h_ref <= 1'b0;
      h_fetch_words <= 4'h0;
    end else if (accept) begin
      h_defer <= d_defer;
      h_cache <= d_cache;
      h_alloc <= d_alloc;
      h_inhibit <= d_inhibit;
      h_error <= d_error;
      h_ref <= d_ref;
      h_fetch_words <= d_fetch_words;
    end
  end

  // Response: next cycle for local outcomes, after acknowledge for bus ones
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_defer <= 1'b0;
      resp_cache <= 1'b0;
      resp_allocate <= 1'b0;
      resp_inhibit <= 1'b0;
      resp_error <= 1'b0;
      resp_ref_set <= 1'b0;
      resp_fetch_words <= 4'h0;
    end else begin
      resp_valid <= (accept & ~d_go_bus) | done;
      resp_defer <= accept ? d_defer : h_defer;
      resp_cache <= accept ? d_cache : h_cache;
      resp_allocate <= accept ? d_alloc : h_alloc;
      resp_inhibit <= accept ? d_inhibit : h_inhibit;
      resp_error <= accept ? d_error : h_error;
      resp_ref_set <= accept ? d_ref : h_ref;
      resp_fetch_words <= accept ? d_fetch_words : h_fetch_words;
    end
  end

  // Activity counters visible to software
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      issue_cnt_q <= '0;
      defer_cnt_q <= '0;
    end else begin
      if (accept && d_go_bus) begin
        issue_cnt_q <= issue_cnt_q + 1'b1;
      end
      if (accept && d_defer) begin
        defer_cnt_q <= defer_cnt_q + 1'b1;
      end
    end
  end

  // APB: access phase takes two cycles so read data comes from a flop
  assign apb_setup = psel & penable & ~pready;
  assign apb_commit = psel & penable & pready;

  // Register read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (paddr == attr_policy_pkg::REG_CTRL) begin
      rd_data[1:0] = ctrl_q;
    end else if (paddr == attr_policy_pkg::REG_STATUS) begin
      rd_data[attr_policy_pkg::STAT_BUSY_BIT] = (state_q != attr_policy_pkg::ST_IDLE);
      rd_data[attr_policy_pkg::STAT_RETRY_BIT] = retry_seen_q;
      rd_data[attr_policy_pkg::STAT_GLOBAL_BIT] = bus_global;
      rd_data[attr_policy_pkg::STAT_INHIBIT_BIT] = resp_inhibit;
    end else if (paddr == attr_policy_pkg::REG_ISSUE_CNT) begin
      rd_data = 32'(issue_cnt_q);
    end else if (paddr == attr_policy_pkg::REG_DEFER_CNT) begin
      rd_data = 32'(defer_cnt_q);
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= ~rd_ok;
      end
    end
  end

  // Control register, written at the completing edge only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= attr_policy_pkg::CTRL_RESET[1:0];
    end else if (apb_commit && pwrite && (paddr == attr_policy_pkg::REG_CTRL)) begin
      ctrl_q <= pwdata[1:0] & attr_policy_pkg::CTRL_MASK;
    end
  end

  // Retry flag: a new retry in the clearing cycle wins over the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retry_seen_q <= 1'b0;
    end else if (bus_req && bus_artry) begin
      retry_seen_q <= 1'b1;
    end else if (apb_commit && pwrite && (paddr == attr_policy_pkg::REG_STATUS) &&
                 pwdata[attr_policy_pkg::STAT_RETRY_BIT]) begin
      retry_seen_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_inhibit_single;
    accept && d_inhibit && d_go_bus |=> bus_req && !bus_burst;
  endproperty
  a_inhibit_single: assert property (p_inhibit_single)
    else $error("inhibited access was not issued as a single beat");
  // A new access may follow at once, so only the cycle after acknowledge is pinned
  property p_one_beat;
    bus_req && bus_ack && !bus_artry |=> !bus_req && resp_valid;
  endproperty
  a_one_beat: assert property (p_one_beat)
    else $error("bus request reissued after acknowledge");
  property p_barrier_noop;
    accept && (req_kind == attr_policy_pkg::KIND_BARRIER) |=>
      resp_valid && !resp_cache && !resp_allocate && !bus_req;
  endproperty
  a_barrier_noop: assert property (p_barrier_noop)
    else $error("barrier touched cache or bus");
  property p_in_order;
    bus_req |-> !req_ready;
  endproperty
  a_in_order: assert property (p_in_order)
    else $error("new access accepted while bus access outstanding");
  property p_global_mark;
    accept && d_go_bus && req_attr[attr_policy_pkg::ATTR_COH_BIT] && req_xlate_en &&
      (req_kind != attr_policy_pkg::KIND_FETCH) |=> bus_req && bus_global;
  endproperty
  a_global_mark: assert property (p_global_mark)
    else $error("coherent access not marked global");
  property p_retry_reissue;
    bus_req && bus_artry |=> !bus_req ##1 bus_req;
  endproperty
  a_retry_reissue: assert property (p_retry_reissue)
    else $error("retried access not reissued after one idle cycle");
  property p_fetch_local;
    bus_req && bus_instr |-> !bus_global;
  endproperty
  a_fetch_local: assert property (p_fetch_local)
    else $error("instruction fetch marked global");
  property p_guarded_load;
    accept && (req_kind == attr_policy_pkg::KIND_LOAD) && !req_required && d_guarded &&
      !req_hit |=> resp_valid && resp_defer && !bus_req;
  endproperty
  a_guarded_load: assert property (p_guarded_load)
    else $error("speculative guarded load missed but was performed");
  property p_block_bound;
    accept |=> resp_fetch_words == attr_policy_pkg::BLOCK_WORDS -
      {1'b0, $past(req_addr[attr_policy_pkg::WORD_IDX_HI:attr_policy_pkg::WORD_IDX_LO])};
  endproperty
  a_block_bound: assert property (p_block_bound)
    else $error("prefetch limit crosses the cache block");
  property p_store_wait;
    accept && (req_kind == attr_policy_pkg::KIND_STORE) && !req_required |=>
      resp_valid && resp_defer && !bus_req;
  endproperty
  a_store_wait: assert property (p_store_wait)
    else $error("speculative store was performed");
  // A speculative access that goes out answers later, so either outcome is allowed here
  property p_error_hold;
    accept && req_err && !req_mchk && !req_required |=>
      !resp_error && (resp_valid || bus_req);
  endproperty
  a_error_hold: assert property (p_error_hold)
    else $error("error reported for speculative access");
  property p_real_mode;
    accept && !req_xlate_en && d_go_bus && (req_kind != attr_policy_pkg::KIND_FETCH) |=>
      bus_global;
  endproperty
  a_real_mode: assert property (p_real_mode)
    else $error("untranslated data access not global");

endmodule // memory_attribute_access_policy
`default_nettype wire

// ### hdl/attr_policy_pkg.sv
// Constants and types shared by the storage attribute policy block
package attr_policy_pkg;

  // Access kinds presented by the load/store and fetch units
  typedef enum logic [1:0] {
    KIND_LOAD,
    KIND_STORE,
    KIND_FETCH,
    KIND_BARRIER
  } access_kind_t;

  // Bus state machine
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_RETRY
  } bus_state_t;

  // Storage attribute bits: write-through, inhibit, coherent, guarded
  localparam int ATTR_W = 4;
  localparam int ATTR_WT_BIT = 3;
  localparam int ATTR_CI_BIT = 2;
  localparam int ATTR_COH_BIT = 1;
  localparam int ATTR_GRD_BIT = 0;
  // Value forced when translation is off: write-back, cacheable, coherent, guarded
  localparam logic [ATTR_W-1:0] ATTR_REAL_MODE = 4'h3;

  // Cache block geometry: 32-byte block of eight 4-byte words
  localparam int WORD_IDX_LO = 2;
  localparam int WORD_IDX_HI = 4;
  localparam logic [3:0] BLOCK_WORDS = 4'h8;

  // APB register map
  localparam int PADDR_W = 12;
  localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
  localparam logic [PADDR_W-1:0] REG_ISSUE_CNT = 12'h008;
  localparam logic [PADDR_W-1:0] REG_DEFER_CNT = 12'h00C;

  // Control fields
  localparam int CTRL_CACHE_EN_BIT = 0;
  localparam int CTRL_SPEC_EN_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
  localparam logic [1:0] CTRL_MASK = 2'h3;

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RETRY_BIT = 1;
  localparam int STAT_GLOBAL_BIT = 2;
  localparam int STAT_INHIBIT_BIT = 3;

endpackage

// ### hdl/attr_decode.sv
// Combinational decode of storage attributes into cache and bus decisions
`timescale 1ns/1ps
`default_nettype none
module attr_decode (
  input wire logic [1:0] kind,
  input wire logic [31:0] addr,
  input wire logic [attr_policy_pkg::ATTR_W-1:0] attr,
  input wire logic xlate_en,
  input wire logic hit,
  input wire logic required,
  input wire logic err,
  input wire logic mchk,
  input wire logic cache_en,
  input wire logic spec_en,
  output logic eff_inhibit,
  output logic eff_guarded,
  output logic global_acc,
  output logic defer,
  output logic use_cache,
  output logic go_bus,
  output logic allocate,
  output logic write,
  output logic instr,
  output logic ref_set,
  output logic error,
  output logic [3:0] fetch_words
);
  logic [attr_policy_pkg::ATTR_W-1:0] eff;
  logic is_load, is_store, is_fetch, is_bar, wt, coh, spec, cached_hit;

  // Translation off forces the fixed attribute value
  assign eff = xlate_en ? attr : attr_policy_pkg::ATTR_REAL_MODE;
  assign is_load = (kind == attr_policy_pkg::KIND_LOAD);
  assign is_store = (kind == attr_policy_pkg::KIND_STORE);
  assign is_fetch = (kind == attr_policy_pkg::KIND_FETCH);
  assign is_bar = (kind == attr_policy_pkg::KIND_BARRIER);
  assign wt = eff[attr_policy_pkg::ATTR_WT_BIT];
  assign coh = eff[attr_policy_pkg::ATTR_COH_BIT];
  assign spec = ~required;
  assign write = is_store;
  assign instr = is_fetch;

  // Disabled cache behaves like inhibited memory; guard bit kept for all six combos
  assign eff_inhibit = eff[attr_policy_pkg::ATTR_CI_BIT] | ~cache_en;
  assign eff_guarded = eff[attr_policy_pkg::ATTR_GRD_BIT];
  // An inhibited location cannot be resident, so a reported hit is ignored
  assign cached_hit = hit & ~eff_inhibit;

  // Coherent data accesses are global; fetches and barriers never are
  assign global_acc = coh & ~is_fetch & ~is_bar;

  // Speculation gating: stores wait; guarded loads only on hit; no guarded fetch ahead
  always_comb begin
    defer = 1'b0;
    if (is_store) begin
      defer = spec;
    end else if (is_load) begin
      defer = spec & (~spec_en | (eff_guarded & ~cached_hit));
    end else if (is_fetch) begin
      defer = spec & (~spec_en | eff_guarded);
    end
  end

  // Barrier does nothing; hits served locally; write-through stores also go out
  assign use_cache = ~defer & ~is_bar & cached_hit;
  assign go_bus = ~defer & ~is_bar & (eff_inhibit | ~cached_hit | (is_store & wt));
  // Only cacheable misses fill a whole block; write-through store misses do not
  assign allocate = go_bus & ~eff_inhibit & ~cached_hit & ~(is_store & wt);

  // Only side effect of abandoned speculative load is the referenced flag
  assign ref_set = is_load & spec & xlate_en & ~defer;
  // Machine checks always reported; other errors only once required
  assign error = mchk | (err & required);
  // Prefetch stops at the end of the current block
  assign fetch_words = attr_policy_pkg::BLOCK_WORDS -
                       {1'b0, addr[attr_policy_pkg::WORD_IDX_HI:attr_policy_pkg::WORD_IDX_LO]};
endmodule // attr_decode
`default_nettype wire

// ### dv/bus_partner.sv
// Behavioural system bus slave with a snooping master that may hold modified data
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_req,
  input wire logic [3:0] delay,
  input wire logic snoop_dirty,
  output logic bus_ack,
  output logic bus_artry,
  output logic [7:0] pushes
);
  logic [3:0] cnt_q;
  logic retried_q;

  // Answer after delay cycles; a dirty snooper retries once, then pushes its data out
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'h0;
      bus_artry <= 1'h0;
      pushes <= 8'h00;
      cnt_q <= 4'h0;
      retried_q <= 1'h0;
    end else begin
      bus_ack <= 1'h0;
      bus_artry <= 1'h0;
      // The answer pulse ends the phase, so never answer twice for one request
      if (bus_req && !bus_ack && !bus_artry) begin
        if (cnt_q == delay) begin
          cnt_q <= 4'h0;
          if (snoop_dirty && !retried_q) begin
            bus_artry <= 1'h1;
            retried_q <= 1'h1;
            pushes <= pushes + 8'h01;
          end else begin
            bus_ack <= 1'h1;
            retried_q <= 1'h0;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else begin
        cnt_q <= 4'h0;
      end
    end
  end
endmodule // bus_partner
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the storage attribute access policy block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic [attr_policy_pkg::PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat, req_addr, bus_addr, b_addr;
  logic req_valid, req_xlate_en, req_hit, req_required, req_err, req_mchk, req_ready;
  logic [1:0] req_kind;
  logic [attr_policy_pkg::ATTR_W-1:0] req_attr;
  logic resp_valid, resp_defer, resp_cache, resp_allocate, resp_inhibit, resp_error;
  logic resp_ref_set, rd, rc, ra, ri, re, rs;
  logic [3:0] resp_fetch_words, rfw, delay;
  logic bus_req, bus_write, bus_instr, bus_global, bus_burst, bus_ack, bus_artry, dirty;
  logic b_glob, b_burst, b_instr, b_write, b_prev;
  logic [7:0] pushes;
  logic [2:0] w;
  int errors = 0;
  int num_checks = 0;
  int nbus = 0;
  int nb = 0;
  int ndef = 0;

  memory_attribute_access_policy #(.CNT_W(16)) dut (.clock, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_kind, .req_addr, .req_attr,
    .req_xlate_en, .req_hit, .req_required, .req_err, .req_mchk, .req_ready,
    .resp_valid, .resp_defer, .resp_cache, .resp_allocate, .resp_inhibit, .resp_error,
    .resp_ref_set, .resp_fetch_words, .bus_req, .bus_addr, .bus_write, .bus_instr,
    .bus_global, .bus_burst, .bus_ack, .bus_artry);

  bus_partner far_end (.clock, .rst_n, .bus_req, .delay, .snoop_dirty(dirty), .bus_ack,
    .bus_artry, .pushes);

  always #12.5 clock = ~clock;

  // Count each new address phase and keep its attributes for the checks
  always @(posedge clock) begin
    if (bus_req === 1'h1 && b_prev !== 1'h1) begin
      nbus++;
      {b_glob, b_burst, b_instr, b_write, b_addr} = {bus_global, bus_burst, bus_instr,
        bus_write, bus_addr};
    end
    b_prev = bus_req;
  end

  // Wide enough that packed flag groups above 32 bits are compared whole
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    begin
      num_checks++;
      if (s !== e) begin
        errors++;
        $display("ERROR %0t seen %0h expected %0h", $time, s, e);
      end
    end
  endtask

  task automatic end_sim;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  // One APB transfer; the trailing edge keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      // Only the watchdog ends a wait that never sees pready
      do begin
        @(posedge clock);
      end while (pready !== 1'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
    end
  endtask

  // Present one access, wait until taken, then until its outcome pulse
  task automatic acc(input logic [1:0] k, input logic [3:0] a, input logic [31:0] ad,
      input logic x, input logic h, input logic r, input logic e);
    int n0;
    begin
      n0 = nbus;
      req_valid <= 1'h1;
      {req_kind, req_attr, req_addr} <= {k, a, ad};
      {req_xlate_en, req_hit, req_required, req_err} <= {x, h, r, e};
      do begin
        @(posedge clock);
      end while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      do begin
        @(posedge clock);
      end while (resp_valid !== 1'h1);
      {rd, rc, ra, ri, re, rs, rfw} = {resp_defer, resp_cache, resp_allocate, resp_inhibit,
        resp_error, resp_ref_set, resp_fetch_words};
      nb = nbus - n0;
    end
  endtask

  // Longest path is a few hundred cycles; this bound only catches a hang
  initial begin
    #(25 * 20000);
    errors++;
    end_sim;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, dirty} = '0;
    {req_valid, req_kind, req_addr, req_attr, req_xlate_en, req_hit} = '0;
    {req_required, req_err, req_mchk, delay} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    apb(1'h0, attr_policy_pkg::REG_CTRL, 32'h0);
    chk(rdat, 32'h3);
    apb(1'h0, 12'h010, 32'h0);
    chk({rerr, rdat}, 33'h1_0000_0000);
    // Every allowed write-through/inhibit/coherent mix with both guard values, hits
    for (int i = 0; i < 24; i++) begin
      w = 3'(i % 6);
      acc(2'(i / 12), {w, 1'(i / 6 % 2)}, 32'h100 + 32'(i * 4), 1'h1, 1'h1, 1'h1, 1'h0);
      chk({ri, ra, rd}, {w[1], 2'h0});
      chk(rc, !w[1]);
      chk(nb, w[1] | (w[2] & i >= 12));
      if (nb == 1) chk({b_glob, b_burst}, {w[0], 1'h0});
      if (nb == 1) chk(b_addr, 32'h100 + 32'(i * 4));
    end
    acc(2'h1, 4'h2, 32'h200, 1'h1, 1'h0, 1'h1, 1'h0);
    chk({b_burst, ra, b_glob}, 3'h7);
    acc(2'h1, 4'hA, 32'h204, 1'h1, 1'h0, 1'h1, 1'h0);
    chk({b_burst, ra, b_write, b_glob}, 4'h3);
    // Slow far end for the fetches
    delay <= 4'h3;
    acc(2'h2, 4'h2, 32'h30C, 1'h1, 1'h0, 1'h1, 1'h0);
    chk({b_glob, b_instr}, 2'h1);
    chk(rfw, 4'h5);
    acc(2'h2, 4'h1, 32'h31C, 1'h1, 1'h0, 1'h1, 1'h0);
    chk({rd, rfw}, 5'h01);
    delay <= 4'h0;
    acc(2'h3, 4'h4, 32'h400, 1'h1, 1'h0, 1'h1, 1'h0);
    chk({nb, rd, rc}, 34'h0);
    acc(2'h1, 4'h0, 32'h404, 1'h1, 1'h1, 1'h0, 1'h0);
    chk({nb, rd}, 33'h1);
    acc(2'h0, 4'h1, 32'h408, 1'h1, 1'h0, 1'h0, 1'h0);
    chk({nb, rd}, 33'h1);
    acc(2'h0, 4'h1, 32'h40C, 1'h1, 1'h1, 1'h0, 1'h0);
    chk({nb, rd, rc}, 34'h1);
    chk(rs, 1'h1);
    acc(2'h0, 4'h0, 32'h410, 1'h1, 1'h1, 1'h0, 1'h1);
    chk(re, 1'h0);
    acc(2'h0, 4'h0, 32'h414, 1'h1, 1'h1, 1'h1, 1'h1);
    chk(re, 1'h1);
    // A machine check is reported even while the access is still speculative
    req_mchk <= 1'h1;
    acc(2'h0, 4'h0, 32'h420, 1'h1, 1'h1, 1'h0, 1'h0);
    req_mchk <= 1'h0;
    chk(re, 1'h1);
    acc(2'h2, 4'h1, 32'h418, 1'h1, 1'h0, 1'h0, 1'h0);
    chk({nb, rd}, 33'h1);
    ndef = 3;
    acc(2'h0, 4'h4, 32'h500, 1'h0, 1'h0, 1'h1, 1'h0);
    chk({ri, b_glob, b_burst}, 3'h3);
    // A dirty snooper forces a retry; the access must be reissued unchanged
    dirty <= 1'h1;
    acc(2'h0, 4'h6, 32'h600, 1'h1, 1'h0, 1'h1, 1'h0);
    dirty <= 1'h0;
    chk({nb, pushes, ri}, {32'h2, 8'h01, 1'h1});
    chk({b_addr, b_glob}, 33'h0_0C01);
    // Status: idle, retry seen, last access global and inhibited
    apb(1'h0, attr_policy_pkg::REG_STATUS, 32'h0);
    chk(rdat[3:0], 4'hE);
    apb(1'h1, attr_policy_pkg::REG_STATUS, 32'h2);
    apb(1'h0, attr_policy_pkg::REG_STATUS, 32'h0);
    chk(rdat[3:0], 4'hC);
    // Cache and speculation switched off: hits still bypass, speculation waits
    apb(1'h1, attr_policy_pkg::REG_CTRL, 32'h0);
    acc(2'h0, 4'h0, 32'h700, 1'h1, 1'h1, 1'h1, 1'h0);
    chk({ri, nb, b_burst}, 34'h2_0000_0002);
    acc(2'h0, 4'h0, 32'h704, 1'h1, 1'h1, 1'h0, 1'h0);
    chk(rd, 1'h1);
    apb(1'h1, attr_policy_pkg::REG_CTRL, 32'h3);
    apb(1'h1, attr_policy_pkg::REG_DEFER_CNT, 32'h0);
    apb(1'h0, attr_policy_pkg::REG_DEFER_CNT, 32'h0);
    chk(rdat, 32'(ndef + 1));
    end_sim;
  end
endmodule // testbench
`default_nettype wire
